// ### hdl/pmu_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmu_cfg.svh"

// Notes on behaviour
// [RULE1] four 64-bit event counters, each with its own event selector.
// [RULE2] only counters and selectors 3..6 work; 7..31 read as zero.
// [RULE3] a cycle counter and a retired-instruction counter are also kept.
// [RULE4] group control sits at csr 0x7D0, bit 0 writable, 31:1 read zero.
// [RULE5] group enable 0 stops all four event counters, 1 runs; resets to 1.
// [RULE6] the group enable only gates incrementing, never touches values.
// [RULE7] unused control bits read zero; writable fields read legal values.
// [RULE8] in firmware halt every counter, cycle counter too, stops.
// [RULE9] in debug halt the stop-count bit decides whether counters run.
// [RULE10] dma traffic during those halts is served but counts nothing.
// [RULE11] a pause instruction leaves the counters running.
// [RULE12] reads see the value before the increment; writes land after it.
// [RULE13] firmware should clear the group enable around counter updates.
// [RULE14] selectors take any value, clamping above the top event code.
// [RULE15] code 0 counts nothing, 1 counts active cycles, 2 cache hits.
// [RULE16] the top event code is 50; larger writes store 50.
// [RULE17] counters have low and high csr halves; carry crosses same cycle.
module pmu_unit (
	// clock and reset
	input  wire logic                     sys_clk,
	input  wire logic                     reset,
	// csr access port
	input  wire logic                     csr_rd_en,
	input  wire logic                     csr_wr_en,
	input  wire logic [11:0]              csr_addr,
	input  wire logic [31:0]              csr_wdata,
	output logic [31:0]                   csr_rdata,
	// pipeline events, bits 0 and 1 are made inside
	input  wire logic [`PMU_NUM_EVT-1:0]  event_pulse,
	input  wire logic [1:0]               retire_count,
	// core state
	input  wire logic                     firmware_halt_state,
	input  wire logic                     debug_halt_state,
	input  wire logic                     dcsr_stop_count,
	input  wire logic                     pause_active
);
	// -----------------------------------------------------------
	// decode
	// -----------------------------------------------------------
	function automatic logic csr_is(input pmu_pkg::pmu_csr_t a,
		input pmu_pkg::pmu_csr_t base, input int i);
		csr_is = (a == (base + i[11:0]));
	endfunction : csr_is

	logic                              group_en;
	logic                              count_ok;
	logic [`PMU_NUM_EVT-1:0]           events;
	pmu_pkg::pmu_cnt_t                 cycle_cnt;
	pmu_pkg::pmu_cnt_t                 instret_cnt;
	pmu_pkg::pmu_cnt_t                 hpm_cnt [`PMU_NUM_HPM];
	pmu_pkg::pmu_evt_t                 hpm_sel [`PMU_NUM_HPM];
	logic [`PMU_NUM_HPM-1:0]           hpm_hit;
	logic [1:0]                        instret_inc;
	logic [1:0]                        cycle_inc;
	logic [31:0]                       next_rdata;

	// -----------------------------------------------------------
	// count permission
	// -----------------------------------------------------------
	// pause_active deliberately plays no part: counting goes on [RULE11]
	// firmware halt, and debug halt with stop-count, gate every counter, so dma cycles in them count nothing
	always_comb begin
		count_ok = !firmware_halt_state // [RULE8] [RULE10]
			&& !(debug_halt_state && dcsr_stop_count); // [RULE9]
	end

	// code 0 never fires, code 1 fires on every running cycle [RULE15]
	always_comb begin
		events = event_pulse;
		events[`PMU_EVT_NONE] = 1'b0;
		events[`PMU_EVT_CLK_ACTIVE] = 1'b1;
	end

	// -----------------------------------------------------------
	// group control
	// -----------------------------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			group_en <= `PMU_GROUP_EN_RESET; // [RULE5]
		end else if (csr_wr_en && csr_is(csr_addr, `PMU_CSR_GROUP_CTRL, 0)) begin
			group_en <= csr_wdata[`PMU_GROUP_EN_BIT]; // [RULE4]
		end
	end

	// -----------------------------------------------------------
	// standard counters
	// -----------------------------------------------------------
	assign cycle_inc   = {1'b0, count_ok}; // [RULE3] [RULE8]
	assign instret_inc = count_ok ? retire_count : 2'h0;

	pmu_counter u_cycle (
		.sys_clk (sys_clk),
		.reset   (reset),
		.inc_amt (cycle_inc),
		.wr_lo   (csr_wr_en && csr_is(csr_addr, `PMU_CSR_CYCLE_LO, 0)),
		.wr_hi   (csr_wr_en && csr_is(csr_addr, `PMU_CSR_CYCLE_HI, 0)),
		.wdata   (csr_wdata),
		.value   (cycle_cnt)
	);

	pmu_counter u_instret (
		.sys_clk (sys_clk),
		.reset   (reset),
		.inc_amt (instret_inc),
		.wr_lo   (csr_wr_en && csr_is(csr_addr, `PMU_CSR_INSTRET_LO, 0)),
		.wr_hi   (csr_wr_en && csr_is(csr_addr, `PMU_CSR_INSTRET_HI, 0)),
		.wdata   (csr_wdata),
		.value   (instret_cnt)
	);

	// -----------------------------------------------------------
	// event counters
	// -----------------------------------------------------------
	// group enable only gates the increment, values are never reset
	genvar g;
	generate
		for (g = 0; g < `PMU_NUM_HPM; g++) begin : g_hpm
			logic [1:0] inc;

			pmu_event_sel u_sel ( // [RULE1]
				.sys_clk (sys_clk),
				.reset   (reset),
				.wr      (csr_wr_en && csr_is(csr_addr, `PMU_CSR_SEL, g)),
				.wdata   (csr_wdata),
				.events  (events),
				.sel     (hpm_sel[g]),
				.hit     (hpm_hit[g])
			);

			// [RULE5] [RULE6]
			assign inc = {1'b0, hpm_hit[g] && group_en && count_ok};

			pmu_counter u_cnt (
				.sys_clk (sys_clk),
				.reset   (reset),
				.inc_amt (inc),
				.wr_lo   (csr_wr_en && csr_is(csr_addr, `PMU_CSR_HPM_LO, g)),
				.wr_hi   (csr_wr_en && csr_is(csr_addr, `PMU_CSR_HPM_HI, g)),
				.wdata   (csr_wdata),
				.value   (hpm_cnt[g])
			);
		end
	endgenerate

	// -----------------------------------------------------------
	// read path
	// -----------------------------------------------------------
	// unlisted numbers, counters 7..31 and selectors 7..31 return zero
	always_comb begin
		next_rdata = 32'h0; // [RULE2] [RULE7]
		if (csr_is(csr_addr, `PMU_CSR_GROUP_CTRL, 0)) begin
			next_rdata = {31'h0, group_en}; // [RULE4]
		end
		if (csr_is(csr_addr, `PMU_CSR_CYCLE_LO, 0)) begin
			next_rdata = cycle_cnt[31:0];
		end
		if (csr_is(csr_addr, `PMU_CSR_CYCLE_HI, 0)) begin
			next_rdata = cycle_cnt[63:32];
		end
		if (csr_is(csr_addr, `PMU_CSR_INSTRET_LO, 0)) begin
			next_rdata = instret_cnt[31:0];
		end
		if (csr_is(csr_addr, `PMU_CSR_INSTRET_HI, 0)) begin
			next_rdata = instret_cnt[63:32];
		end
		for (int i = 0; i < `PMU_NUM_HPM; i++) begin
			if (csr_is(csr_addr, `PMU_CSR_HPM_LO, i)) begin
				next_rdata = hpm_cnt[i][31:0]; // [RULE17]
			end
			if (csr_is(csr_addr, `PMU_CSR_HPM_HI, i)) begin
				next_rdata = hpm_cnt[i][63:32];
			end
			if (csr_is(csr_addr, `PMU_CSR_SEL, i)) begin
				next_rdata = {26'h0, hpm_sel[i]};
			end
		end
	end

	// sampled before this edge's increment lands [RULE12]
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			csr_rdata <= 32'h0;
		end else if (csr_rd_en) begin
			csr_rdata <= next_rdata;
		end
	end

	// -----------------------------------------------------------
	// checks
	// -----------------------------------------------------------
	logic wr_hpm0;
	logic wr_cycle;
	logic wr_hpm1;
	logic wr_hpm2;
	logic wr_instret;
	assign wr_hpm0  = csr_wr_en && (csr_is(csr_addr, `PMU_CSR_HPM_LO, 0)
		|| csr_is(csr_addr, `PMU_CSR_HPM_HI, 0));
	assign wr_cycle = csr_wr_en && (csr_is(csr_addr, `PMU_CSR_CYCLE_LO, 0)
		|| csr_is(csr_addr, `PMU_CSR_CYCLE_HI, 0));
	assign wr_hpm1  = csr_wr_en && (csr_is(csr_addr, `PMU_CSR_HPM_LO, 1)
		|| csr_is(csr_addr, `PMU_CSR_HPM_HI, 1));
	assign wr_hpm2  = csr_wr_en && (csr_is(csr_addr, `PMU_CSR_HPM_LO, 2)
		|| csr_is(csr_addr, `PMU_CSR_HPM_HI, 2));
	assign wr_instret = csr_wr_en && (csr_is(csr_addr, `PMU_CSR_INSTRET_LO, 0)
		|| csr_is(csr_addr, `PMU_CSR_INSTRET_HI, 0));

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);

	a_group_stops_hpm: assert property ( // [RULE5]
		(!group_en && !wr_hpm0) |=> $stable(hpm_cnt[0]))
		else $error("event counter moved while group disabled");

	a_group_keeps_val: assert property ( // [RULE6]
		(csr_wr_en && csr_is(csr_addr, `PMU_CSR_GROUP_CTRL, 0) && !wr_hpm0)
		|=> (hpm_cnt[0] - $past(hpm_cnt[0])) <= 64'h1)
		else $error("group enable write disturbed a counter");

	a_fw_halt_stop: assert property ( // [RULE8]
		(firmware_halt_state && !wr_cycle)[*2] |=> $stable(cycle_cnt))
		else $error("cycle counter ran in firmware halt");

	a_dbg_stop_cnt: assert property ( // [RULE9]
		(debug_halt_state && dcsr_stop_count && !wr_cycle)
		|=> cycle_cnt == $past(cycle_cnt))
		else $error("cycle counter ran in debug halt with stop-count");

	a_cycle_runs: assert property ( // [RULE3]
		(count_ok && !wr_cycle) |=> cycle_cnt == $past(cycle_cnt) + 64'h1)
		else $error("cycle counter failed to advance");

	a_ctrl_read_zero: assert property ( // [RULE4]
		(csr_rd_en && csr_is(csr_addr, `PMU_CSR_GROUP_CTRL, 0))
		|=> csr_rdata[31:1] == 31'h0 && csr_rdata[0] == $past(group_en))
		else $error("group control read wrong");

	a_unused_reads_0: assert property ( // [RULE2]
		(csr_rd_en && csr_addr == 12'hB07) |=> csr_rdata == 32'h0)
		else $error("unused counter did not read zero");

	a_sel_clamps: assert property ( // [RULE14]
		(csr_wr_en && csr_is(csr_addr, `PMU_CSR_SEL, 1)
		&& csr_wdata > 32'h32) |=> hpm_sel[1] == `PMU_EVT_MAX)
		else $error("selector did not clamp");

	a_read_pre_inc: assert property ( // [RULE12]
		(csr_rd_en && csr_is(csr_addr, `PMU_CSR_CYCLE_LO, 0))
		|=> csr_rdata == $past(cycle_cnt[31:0]))
		else $error("read did not return pre-increment value");

	a_write_wins: assert property ( // [RULE12]
		(csr_wr_en && csr_is(csr_addr, `PMU_CSR_HPM_LO, 2))
		|=> hpm_cnt[2][31:0] == $past(csr_wdata))
		else $error("write did not land after increment");

	a_carry_same: assert property ( // [RULE17]
		(hpm_cnt[3][31:0] == 32'hFFFFFFFF && hpm_hit[3] && group_en
		&& count_ok && !csr_wr_en)
		|=> hpm_cnt[3][63:32] == $past(hpm_cnt[3][63:32]) + 32'h1)
		else $error("carry did not reach the high half");

	a_hpm_counts: assert property ( // [RULE1]
		(hpm_hit[2] && group_en && count_ok && !wr_hpm2)
		|=> hpm_cnt[2] == $past(hpm_cnt[2]) + 64'h1)
		else $error("event counter missed a selected event");

	a_code0_idle: assert property ( // [RULE15]
		(hpm_sel[0] == `PMU_EVT_NONE && !wr_hpm0) |=> $stable(hpm_cnt[0]))
		else $error("event code 0 counted");

	a_code1_every: assert property ( // [RULE15]
		(hpm_sel[1] == `PMU_EVT_CLK_ACTIVE && group_en && count_ok && !wr_hpm1)
		|=> hpm_cnt[1] == $past(hpm_cnt[1]) + 64'h1)
		else $error("event code 1 skipped an active cycle");

	a_pause_runs: assert property ( // [RULE11]
		(pause_active && count_ok && !wr_cycle)
		|=> cycle_cnt == $past(cycle_cnt) + 64'h1)
		else $error("cycle counter stopped during pause");

	a_dma_halt_idle: assert property ( // [RULE10]
		(firmware_halt_state && !wr_hpm2) |=> $stable(hpm_cnt[2]))
		else $error("event counter moved during firmware halt");

	a_dbg_hpm_idle: assert property ( // [RULE9]
		(debug_halt_state && dcsr_stop_count && !wr_hpm1)
		|=> $stable(hpm_cnt[1]))
		else $error("event counter moved in debug halt with stop-count");

	a_instret_gate: assert property ( // [RULE8]
		(!count_ok && !wr_instret) |=> $stable(instret_cnt))
		else $error("retired count moved while halted");

	a_instret_adds: assert property ( // [RULE3]
		(count_ok && !wr_instret)
		|=> instret_cnt == $past(instret_cnt) + {62'h0, $past(retire_count)})
		else $error("retired count added the wrong amount");

	a_upper_sel_zero: assert property ( // [RULE2]
		(csr_rd_en && csr_addr == 12'h327) |=> csr_rdata == 32'h0)
		else $error("unused selector did not read zero");

	a_sel_stores: assert property ( // [RULE14]
		(csr_wr_en && csr_is(csr_addr, `PMU_CSR_SEL, 0)
		&& csr_wdata <= 32'h32) |=> hpm_sel[0] == $past(csr_wdata[5:0]))
		else $error("selector did not store a legal code");

	c_group_off: cover property (group_en ##1 !group_en);
	c_fw_halt: cover property (firmware_halt_state ##1 !firmware_halt_state);
	c_dbg_halt: cover property (debug_halt_state && dcsr_stop_count);
	c_pause_count: cover property (pause_active && hpm_hit[0] && group_en);
	c_sel_clamp: cover property (hpm_sel[0] == `PMU_EVT_MAX);
endmodule : pmu_unit
`default_nettype wire

// ### hdl/pmu_cfg.svh
`ifndef PMU_CFG_SVH
`define PMU_CFG_SVH

// ---------------------------------------------------------------
// csr numbers
// ---------------------------------------------------------------
`define PMU_CSR_GROUP_CTRL   12'h7D0
`define PMU_CSR_CYCLE_LO     12'hB00
`define PMU_CSR_INSTRET_LO   12'hB02
`define PMU_CSR_HPM_LO       12'hB03
`define PMU_CSR_HPM_LO_LAST  12'hB1F
`define PMU_CSR_CYCLE_HI     12'hB80
`define PMU_CSR_INSTRET_HI   12'hB82
`define PMU_CSR_HPM_HI       12'hB83
`define PMU_CSR_HPM_HI_LAST  12'hB9F
`define PMU_CSR_SEL          12'h323
`define PMU_CSR_SEL_LAST     12'h33F

// ---------------------------------------------------------------
// fields, resets, counts
// ---------------------------------------------------------------
`define PMU_GROUP_EN_BIT     0
`define PMU_GROUP_EN_RESET   1'h1
`define PMU_NUM_HPM          4
`define PMU_EVT_MAX          6'h32
`define PMU_EVT_NONE         6'h00
`define PMU_EVT_CLK_ACTIVE   6'h01
`define PMU_NUM_EVT          51

`endif

// ### hdl/pmu_pkg.sv
`default_nettype none

package pmu_pkg;
	typedef logic [5:0]  pmu_evt_t;
	typedef logic [63:0] pmu_cnt_t;
	typedef logic [11:0] pmu_csr_t;
endpackage : pmu_pkg

`default_nettype wire

// ### hdl/pmu_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmu_cfg.svh"

module pmu_counter (
	// clock and reset
	input  wire logic             sys_clk,
	input  wire logic             reset,
	// increment
	input  wire logic [1:0]       inc_amt,
	// csr writes
	input  wire logic             wr_lo,
	input  wire logic             wr_hi,
	input  wire logic [31:0]      wdata,
	// value
	output pmu_pkg::pmu_cnt_t     value
);
	pmu_pkg::pmu_cnt_t next_value;

	// increment first, then the write overrides its half [RULE12] [RULE17]
	always_comb begin
		next_value = value + {62'h0, inc_amt};
		if (wr_lo) begin
			next_value[31:0] = wdata;
		end
		if (wr_hi) begin
			next_value[63:32] = wdata;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			value <= 64'h0;
		end else begin
			value <= next_value;
		end
	end
endmodule : pmu_counter
`default_nettype wire

// ### hdl/pmu_event_sel.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmu_cfg.svh"

module pmu_event_sel (
	// clock and reset
	input  wire logic                       sys_clk,
	input  wire logic                       reset,
	// csr write
	input  wire logic                       wr,
	input  wire logic [31:0]                wdata,
	// events
	input  wire logic [`PMU_NUM_EVT-1:0]    events,
	// selection
	output pmu_pkg::pmu_evt_t               sel,
	output logic                            hit
);
	// any value accepted, above the top code reads back as the top [RULE14]
	function automatic pmu_pkg::pmu_evt_t clamp_evt(input logic [31:0] v);
		if (v > {26'h0, `PMU_EVT_MAX}) begin
			clamp_evt = `PMU_EVT_MAX;
		end else begin
			clamp_evt = v[5:0];
		end
	endfunction : clamp_evt

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			sel <= `PMU_EVT_NONE;
		end else if (wr) begin
			sel <= clamp_evt(wdata); // [RULE16]
		end
	end

	// sel never exceeds the top code, so the index stays in range
	assign hit = events[sel];
endmodule : pmu_event_sel
`default_nettype wire

// ### tb/pmu_core_model.sv
`timescale 1ns/1ps
`default_nettype none

module pmu_core_model (
	// clock
	input  wire logic        sys_clk,
	// csr access port
	output logic             csr_rd_en,
	output logic             csr_wr_en,
	output logic [11:0]      csr_addr,
	output logic [31:0]      csr_wdata,
	// pipeline events
	output logic [50:0]      event_pulse,
	output logic [1:0]       retire_count,
	// core state
	output logic             firmware_halt_state,
	output logic             debug_halt_state,
	output logic             dcsr_stop_count,
	output logic             pause_active
);
	initial begin
		{csr_rd_en, csr_wr_en, csr_addr, csr_wdata} = '0;
		{event_pulse, retire_count} = '0;
		{firmware_halt_state, debug_halt_state} = 2'h0;
		{dcsr_stop_count, pause_active} = 2'h0;
	end

	// ---------------------------------------------------------------
	// one core cycle, launched just after the edge
	// ---------------------------------------------------------------
	task automatic drive(input logic rd, input logic wr,
			input logic [11:0] a, input logic [31:0] d,
			input logic [50:0] ev, input logic [1:0] rc,
			input logic [3:0] st);
		@(posedge sys_clk);
		#1;
		csr_rd_en = rd;
		csr_wr_en = wr;
		// idle bus toggles so a stale address does not stay on the bus
		csr_addr = (rd | wr) ? a : ~csr_addr;
		csr_wdata = wr ? d : ~csr_wdata;
		event_pulse = ev;
		retire_count = rc;
		{pause_active, dcsr_stop_count} = st[3:2];
		{debug_halt_state, firmware_halt_state} = st[1:0];
	endtask : drive

	// quiet update: stop the group around the change
	task automatic safe_write(input logic [11:0] a, input logic [31:0] d);
		drive(0, 1, 12'h7D0, 32'h0, event_pulse, retire_count, 4'h0);
		drive(0, 1, a, d, event_pulse, retire_count, 4'h0);
		drive(0, 1, 12'h7D0, 32'h1, event_pulse, retire_count, 4'h0);
	endtask : safe_write
endmodule : pmu_core_model

`default_nettype wire

// ### tb/perf_event_counter_unit_bench.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end

module perf_event_counter_unit_bench;
	logic              sys_clk = 1'b0;
	logic              reset = 1'b1;
	wire logic         csr_rd_en, csr_wr_en;
	wire logic [11:0]  csr_addr;
	wire logic [31:0]  csr_wdata, csr_rdata;
	wire logic [50:0]  event_pulse;
	wire logic [1:0]   retire_count;
	wire logic         firmware_halt_state, debug_halt_state;
	wire logic         dcsr_stop_count, pause_active;
	int                n_fail = 0;
	int                cmp_count = 0;
	longint unsigned   s = 31;
	longint unsigned   m_cnt[6];
	int                m_sel[4];
	bit                m_gen, m_chk, ok;
	logic [31:0]       m_rd;
	int                m_cls;
	logic [11:0]       tbl[$] = '{12'h7D0, 12'hB00, 12'hB80, 12'hB02,
		12'hB82, 12'hB03, 12'hB04, 12'hB05, 12'hB06, 12'hB83, 12'hB84,
		12'hB85, 12'hB86, 12'h323, 12'h324, 12'h325, 12'h326, 12'hB07,
		12'hB1F, 12'hB87, 12'hB9F, 12'h327, 12'h33F, 12'h7D1, 12'h000};

	always #5 sys_clk = ~sys_clk;

	pmu_unit i_dut (
		.sys_clk             (sys_clk),
		.reset               (reset),
		.csr_rd_en           (csr_rd_en),
		.csr_wr_en           (csr_wr_en),
		.csr_addr            (csr_addr),
		.csr_wdata           (csr_wdata),
		.csr_rdata           (csr_rdata),
		.event_pulse         (event_pulse),
		.retire_count        (retire_count),
		.firmware_halt_state (firmware_halt_state),
		.debug_halt_state    (debug_halt_state),
		.dcsr_stop_count     (dcsr_stop_count),
		.pause_active        (pause_active)
	);

	pmu_core_model i_core (
		.sys_clk             (sys_clk),
		.csr_rd_en           (csr_rd_en),
		.csr_wr_en           (csr_wr_en),
		.csr_addr            (csr_addr),
		.csr_wdata           (csr_wdata),
		.event_pulse         (event_pulse),
		.retire_count        (retire_count),
		.firmware_halt_state (firmware_halt_state),
		.debug_halt_state    (debug_halt_state),
		.dcsr_stop_count     (dcsr_stop_count),
		.pause_active        (pause_active)
	);

	// ---------------------------------------------------------------
	// reference model
	// ---------------------------------------------------------------
	function automatic longint unsigned rnd();
		s ^= s << 13;
		s ^= s >> 7;
		s ^= s << 17;
		return s;
	endfunction : rnd

	function automatic int hidx(input logic [11:0] a);
		return (a[2:0] == 3'h0) ? 0 : int'(a[2:0]) - 1;
	endfunction : hidx

	function automatic logic [31:0] mread(input logic [11:0] a);
		if (a == 12'h7D0) return {31'h0, m_gen};
		if (a inside {12'hB00, 12'hB02, [12'hB03:12'hB06]})
			return m_cnt[hidx(a)][31:0];
		if (a inside {12'hB80, 12'hB82, [12'hB83:12'hB86]})
			return m_cnt[hidx(a)][63:32];
		if (a inside {[12'h323:12'h326]}) return 32'(m_sel[a - 12'h323]);
		return 32'h0;
	endfunction : mread

	function automatic void mwrite(input logic [11:0] a, input logic [31:0] d);
		if (a == 12'h7D0) m_gen = d[0];
		else if (a inside {12'hB00, 12'hB02, [12'hB03:12'hB06]})
			m_cnt[hidx(a)][31:0] = d;
		else if (a inside {12'hB80, 12'hB82, [12'hB83:12'hB86]})
			m_cnt[hidx(a)][63:32] = d;
		else if (a inside {[12'h323:12'h326]})
			m_sel[a - 12'h323] = (d > 50) ? 50 : int'(d);
	endfunction : mwrite

	// which kind of register a read touched, for the report
	function automatic int rclass(input logic [11:0] a);
		if (a inside {12'hB00, 12'hB80, 12'hB02, 12'hB82}) return 0;
		if (a inside {[12'hB03:12'hB06]}) return 1;
		if (a inside {[12'hB83:12'hB86]}) return 2;
		if (a inside {[12'h323:12'h326]}) return 3;
		if (a == 12'h7D0) return 4;
		return 5;
	endfunction : rclass

	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			foreach (m_cnt[i]) m_cnt[i] = 0;
			foreach (m_sel[i]) m_sel[i] = 0;
			m_gen = 1'b1;
			m_chk <= 1'b0;
		end else begin
			ok = !firmware_halt_state && !(debug_halt_state && dcsr_stop_count);
			m_chk <= csr_rd_en;
			if (csr_rd_en) begin
				m_rd <= mread(csr_addr);
				m_cls <= rclass(csr_addr);
			end
			m_cnt[0] += ok;
			m_cnt[1] += ok ? retire_count : 0;
			for (int i = 0; i < 4; i++)
				if (ok && m_gen && (m_sel[i] == 1 || (m_sel[i] > 1 && event_pulse[m_sel[i]])))
					m_cnt[i + 2]++;
			if (csr_wr_en) mwrite(csr_addr, csr_wdata);
		end
	end

	// read data is registered: look one edge after the request
	always @(posedge sys_clk) begin
		#2;
		if (m_chk) begin
			case (m_cls)
				0: `CHK("std", m_rd, csr_rdata)
				1: `CHK("hpm_lo", m_rd, csr_rdata)
				2: `CHK("hpm_hi", m_rd, csr_rdata)
				3: `CHK("sel", m_rd, csr_rdata)
				4: `CHK("ctrl", m_rd, csr_rdata)
				default: `CHK("zero", m_rd, csr_rdata)
			endcase
		end
	end

	// ---------------------------------------------------------------
	// stimulus
	// ---------------------------------------------------------------
	task automatic step(input logic rd, input logic wr,
			input logic [11:0] a, input logic [31:0] d);
		longint unsigned r1, r2;
		r1 = rnd();
		r2 = rnd();
		i_core.drive(rd, wr, a, d, r1[50:0], 2'(r2 % 3),
			{r2[7], r2[8], r2[9], r2[12:10] == 3'h0});
	endtask : step

	task automatic final_report();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report

	initial begin
		#100000;
		n_fail++;
		final_report();
	end

	initial begin
		longint unsigned r;
		logic [11:0]     a;
		repeat (4) @(posedge sys_clk);
		#1;
		reset = 1'b0;
		foreach (tbl[i]) step(0, 1, tbl[i], 32'hFFFFFFFF);
		foreach (tbl[i]) step(1, 0, tbl[i], 32'h0);
		for (int c = 0; c < 53; c++) begin
			step(0, 1, 12'h323 + 12'(c % 4), 32'(c));
			step(1, 0, 12'h323 + 12'(c % 4), 32'h0);
		end
		step(0, 1, 12'h324, 32'h1);
		step(0, 1, 12'h7D0, 32'hFFFFFFFE);
		step(0, 1, 12'hB04, 32'hFFFFFFFC);
		repeat (8) step(1, 0, 12'hB84, 32'h0);
		i_core.safe_write(12'hB84, 32'h12345678);
		step(1, 1, 12'hB84, 32'h0000ABCD);
		for (int n = 0; n < 4000; n++) begin
			r = rnd();
			a = tbl[r % tbl.size()];
			if (r[42]) step(r[40], r[41] && !(a inside {12'hB00, 12'hB80,
				12'hB02, 12'hB82}), a, {28'hFFFFFFF, r[3:0]});
			else step(r[40], r[41] && !(a inside {12'hB00, 12'hB80,
				12'hB02, 12'hB82}), a, r[63:32]);
		end
		step(0, 0, 12'h0, 32'h0);
		step(0, 0, 12'h0, 32'h0);
		final_report();
	end
endmodule : perf_event_counter_unit_bench

`default_nettype wire
